/* rtl/tfr_bank.sv */
// configuration and fault register bank of a line transceiver, with serial pin routing
// assumes fault inputs are asynchronous levels from analog detectors, pins are asynchronous
`timescale 1ns/100ps

module tfr_bank
   import tfr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spi_mode_pin,
   input wire logic serial_route_select,
   input wire logic chip_sel_pin,
   input wire logic shared_in_pin,
   input wire logic shared_clock_pin,
   input wire logic uart_tx_pin,
   input wire logic transmit_enable_pin,
   input wire logic line_rx_in,
   input wire logic overheat_shutdown_in,
   input wire logic driver_fault_in,
   input wire logic supply_low_warn_in,
   input wire logic supply_lockout_in,
   input wire logic temp_warn_in,
   input wire logic wakeup_detect_in,
   input wire logic aux_input_low_in,
   input wire logic line_level_low_in,
   output logic fault_irq_out_n,
   output logic shared_out_pin,
   output logic shared_out_oe,
   output logic uart_rx_pin,
   output logic line_tx_out,
   output logic line_transmit_enable_pin_out,
   output tfr_byte_t mode_control_out,
   output tfr_byte_t driver_current_limit_out,
   output tfr_byte_t line_driver_config_out,
   output tfr_byte_t aux_input_config_out,
   output tfr_byte_t line_polarity_invert_out
);
   localparam int SYNC_W = 16;

   tfr_reg_if rif ();

   logic [SYNC_W-1:0] pins_meta_reg;
   logic [SYNC_W-1:0] pins_sync_reg;
   logic spi_mode_s;
   logic route_sel_s;
   logic cs_n_s;
   logic sdi_s;
   logic sck_s;
   logic dtx_s;
   logic dtxen_s;
   logic rx_s;
   logic shut_s;
   logic fault_s;
   logic warn_s;
   logic lock_s;
   logic temp_s;
   logic wake_s;
   logic aux_low_s;
   logic line_low_s;
   logic [5:0] cond_prev_reg;
   logic [5:0] cond_now;
   logic [5:0] cond_rise;

   tfr_byte_t irq_flags_reg;
   tfr_byte_t irq_flags_next;
   tfr_byte_t irq_set;
   tfr_byte_t irq_clr;
   tfr_byte_t status_view;
   tfr_byte_t mode_reg;
   tfr_byte_t curlim_reg;
   tfr_byte_t linecfg_reg;
   tfr_byte_t auxcfg_reg;
   tfr_byte_t invert_reg;
   tfr_byte_t rdata;
   logic soft_rst;
   logic wake_dis;
   logic share_en;
   logic warn_en;
   logic fault_irq_n_reg;

   tfr_route_t route;
   logic spi_active;
   logic spi_cs_n;
   logic miso;
   logic shared_out_reg;
   logic shared_oe_reg;
   logic uart_rx_reg;
   logic line_tx_reg;
   logic line_transmit_enable_pin_reg;

   // every asynchronous input passes two flip-flops before anything reads it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins_meta_reg <= `TFR_SYNC_IDLE;
         pins_sync_reg <= `TFR_SYNC_IDLE;
      end else begin
         pins_meta_reg <= {spi_mode_pin, serial_route_select, chip_sel_pin, shared_in_pin,
                           shared_clock_pin, uart_tx_pin, transmit_enable_pin, line_rx_in,
                           overheat_shutdown_in, driver_fault_in, supply_low_warn_in,
                           supply_lockout_in, temp_warn_in, wakeup_detect_in,
                           aux_input_low_in, line_level_low_in};
         pins_sync_reg <= pins_meta_reg;
      end
   end

   assign {spi_mode_s, route_sel_s, cs_n_s, sdi_s, sck_s, dtx_s, dtxen_s, rx_s,
           shut_s, fault_s, warn_s, lock_s, temp_s, wake_s, aux_low_s, line_low_s}
      = pins_sync_reg;

   assign soft_rst = mode_reg[`TFR_MODE_BIT_SOFTRST];
   assign wake_dis = mode_reg[`TFR_MODE_BIT_WAKEDIS];
   assign share_en = mode_reg[`TFR_MODE_BIT_SHARE];
   assign warn_en = mode_reg[`TFR_MODE_BIT_WARNEN];

   // events are edges of the condition, so a lasting fault raises its flag once
   assign cond_now = {shut_s, wake_s, fault_s, warn_s, lock_s, temp_s};
   assign cond_rise = cond_now & ~cond_prev_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         cond_prev_reg <= '0;
      else
         cond_prev_reg <= cond_now;
   end

   // no flags in pin mode or while the soft reset bit is held
   always_comb begin
      irq_set = `TFR_BYTE_ZERO;
      irq_set[`TFR_BIT_SHUT] = cond_rise[5];
      irq_set[`TFR_BIT_WAKE] = cond_rise[4] & ~wake_dis;
      irq_set[`TFR_BIT_FAULT] = cond_rise[3];
      irq_set[`TFR_BIT_LOWWARN] = cond_rise[2] & warn_en;
      irq_set[`TFR_BIT_LOCKOUT] = cond_rise[1];
      irq_set[`TFR_BIT_TEMP] = cond_rise[0];
      if (!spi_mode_s || soft_rst)
         irq_set = `TFR_BYTE_ZERO;
   end

   // read clears everything, but an event in the same cycle survives the clear
   assign irq_clr = (rif.rd_pulse && rif.addr == `TFR_ADDR_IRQ) ? `TFR_BYTE_ONES
                                                               : `TFR_BYTE_ZERO;
   assign irq_flags_next = soft_rst ? `TFR_REG_RESET
      : ((irq_flags_reg & ~irq_clr) | irq_set) & `TFR_IRQ_USED_MASK;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         irq_flags_reg <= `TFR_REG_RESET;
      else
         irq_flags_reg <= irq_flags_next;
   end

   // pin follows the flags; it reasserts only when a new event sets one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         fault_irq_n_reg <= 1'b1;
      else
         fault_irq_n_reg <= ~|irq_flags_next;
   end

   assign status_view = soft_rst ? `TFR_BYTE_ZERO
      : {shut_s, aux_low_s, 1'b0, fault_s, warn_s, lock_s, line_low_s, temp_s};

   // while soft reset is held the other registers sit at their power-up value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= `TFR_REG_RESET;
      end else if (rif.wr_pulse && rif.addr == `TFR_ADDR_MODE) begin
         mode_reg <= rif.wdata;
      end else if (soft_rst) begin
         mode_reg <= mode_reg & `TFR_TOPBIT_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         curlim_reg <= `TFR_REG_RESET;
         linecfg_reg <= `TFR_REG_RESET;
         auxcfg_reg <= `TFR_REG_RESET;
         invert_reg <= `TFR_REG_RESET;
      end else if (soft_rst) begin
         curlim_reg <= `TFR_REG_RESET;
         linecfg_reg <= `TFR_REG_RESET;
         auxcfg_reg <= `TFR_REG_RESET;
         invert_reg <= `TFR_REG_RESET;
      end else if (rif.wr_pulse) begin
         unique case (rif.addr)
            `TFR_ADDR_CURLIM: curlim_reg <= rif.wdata;
            `TFR_ADDR_LINECFG: linecfg_reg <= rif.wdata & `TFR_LINECFG_MASK;
            `TFR_ADDR_AUXCFG: auxcfg_reg <= rif.wdata & `TFR_TOPBIT_MASK;
            `TFR_ADDR_INVERT: invert_reg <= rif.wdata & `TFR_TOPBIT_MASK;
            default: ;
         endcase
      end
   end

   // the read snapshot is taken on the clearing edge from the old value, so it shows the flags as they were before the clear
   always_comb begin
      rdata = `TFR_BYTE_ZERO;
      case (rif.addr)
         `TFR_ADDR_IRQ: rdata = irq_flags_reg;
         `TFR_ADDR_STATUS: rdata = status_view;
         `TFR_ADDR_MODE: rdata = mode_reg;
         `TFR_ADDR_CURLIM: rdata = curlim_reg;
         `TFR_ADDR_LINECFG: rdata = linecfg_reg;
         `TFR_ADDR_AUXCFG: rdata = auxcfg_reg;
         `TFR_ADDR_INVERT: rdata = invert_reg;
         default: rdata = `TFR_BYTE_ZERO;
      endcase
   end
   assign rif.rdata = rdata;

   always_comb begin
      if (!spi_mode_s)
         route = TFR_ROUTE_PIN;
      else if (!share_en)
         route = TFR_ROUTE_PARALLEL;
      else if (route_sel_s)
         route = TFR_ROUTE_MUX_UART;
      else
         route = TFR_ROUTE_MUX_SPI;
   end

   assign spi_active = (route == TFR_ROUTE_PARALLEL) || (route == TFR_ROUTE_MUX_SPI);
   // chip select means nothing in the uart route, so the engine is held idle there
   assign spi_cs_n = cs_n_s | ~spi_active;

   tfr_spi_engine u_engine (
      .clk(clk),
      .rst_n(rst_n),
      .sck_s(sck_s),
      .cs_n_s(spi_cs_n),
      .mosi_s(sdi_s),
      .bus(rif.eng),
      .miso(miso)
   );

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shared_out_reg <= 1'b0;
         shared_oe_reg <= 1'b0;
         line_tx_reg <= 1'b0;
         line_transmit_enable_pin_reg <= 1'b0;
         uart_rx_reg <= 1'b1;
      end else begin
         uart_rx_reg <= rx_s;
         unique case (route)
            TFR_ROUTE_PIN: begin
               shared_out_reg <= 1'b0;
               shared_oe_reg <= 1'b0;
               line_tx_reg <= dtx_s;
               line_transmit_enable_pin_reg <= dtxen_s;
            end
            TFR_ROUTE_PARALLEL: begin
               shared_out_reg <= miso;
               shared_oe_reg <= ~spi_cs_n;
               line_tx_reg <= dtx_s;
               line_transmit_enable_pin_reg <= dtxen_s;
            end
            TFR_ROUTE_MUX_SPI: begin
               shared_out_reg <= miso;
               shared_oe_reg <= ~spi_cs_n;
               line_tx_reg <= 1'b0;
               line_transmit_enable_pin_reg <= 1'b0;
            end
            TFR_ROUTE_MUX_UART: begin
               shared_out_reg <= rx_s;
               shared_oe_reg <= 1'b1;
               line_tx_reg <= sdi_s;
               line_transmit_enable_pin_reg <= sck_s;
            end
         endcase
      end
   end

   assign fault_irq_out_n = fault_irq_n_reg;
   assign shared_out_pin = shared_out_reg;
   assign shared_out_oe = shared_oe_reg;
   assign uart_rx_pin = uart_rx_reg;
   assign line_tx_out = line_tx_reg;
   assign line_transmit_enable_pin_out = line_transmit_enable_pin_reg;
   assign mode_control_out = mode_reg;
   assign driver_current_limit_out = curlim_reg;
   assign line_driver_config_out = linecfg_reg;
   assign aux_input_config_out = auxcfg_reg;
   assign line_polarity_invert_out = invert_reg;
endmodule

/* rtl/tfr_pkg.sv */
// types shared by the fault register bank and its serial engine
// assumes tfr_regs.svh supplies the widths
`include "tfr_regs.svh"

package tfr_pkg;
   typedef logic [`TFR_DATA_W-1:0] tfr_byte_t;
   typedef logic [`TFR_ADDR_W-1:0] tfr_addr_t;
   // how the shared serial pins are routed
   typedef enum logic [3:0] {
      TFR_ROUTE_PIN = 4'b0001,
      TFR_ROUTE_PARALLEL = 4'b0010,
      TFR_ROUTE_MUX_SPI = 4'b0100,
      TFR_ROUTE_MUX_UART = 4'b1000
   } tfr_route_t;
endpackage

/* rtl/tfr_reg_if.sv */
// register access bundle between the serial engine and the register bank
// assumes both ends run on the same clock
`timescale 1ns/100ps

interface tfr_reg_if;
   import tfr_pkg::*;
   tfr_addr_t addr;
   logic rd_pulse;
   logic wr_pulse;
   tfr_byte_t wdata;
   tfr_byte_t rdata;
   modport eng (
      output addr,
      output rd_pulse,
      output wr_pulse,
      output wdata,
      input rdata
   );
   modport bank (
      input addr,
      input rd_pulse,
      input wr_pulse,
      input wdata,
      output rdata
   );
endinterface

/* rtl/tfr_regs.svh */
// register map, field positions, masks and reset values of the fault register bank
// assumes byte-wide registers addressed by a three-bit index
`ifndef TFR_REGS_SVH
`define TFR_REGS_SVH

`define TFR_ADDR_W 3
`define TFR_DATA_W 8
`define TFR_ADDR_IRQ 3'h0
`define TFR_ADDR_STATUS 3'h1
`define TFR_ADDR_MODE 3'h2
`define TFR_ADDR_CURLIM 3'h3
`define TFR_ADDR_LINECFG 3'h4
`define TFR_ADDR_AUXCFG 3'h5
`define TFR_ADDR_INVERT 3'h6

`define TFR_BIT_SHUT 7
`define TFR_BIT_WAKE 6
`define TFR_BIT_FAULT 4
`define TFR_BIT_LOWWARN 3
`define TFR_BIT_LOCKOUT 2
`define TFR_BIT_TEMP 0

`define TFR_MODE_BIT_SOFTRST 7
`define TFR_MODE_BIT_WAKEDIS 6
`define TFR_MODE_BIT_SHARE 4
`define TFR_MODE_BIT_WARNEN 3

`define TFR_IRQ_USED_MASK 8'hdd
`define TFR_LINECFG_MASK 8'hef
`define TFR_TOPBIT_MASK 8'h80
`define TFR_REG_RESET 8'h00
`define TFR_BYTE_ZERO 8'h00
`define TFR_BYTE_ONES 8'hff
// chip select and receive line idle high, so no false level follows reset
`define TFR_SYNC_IDLE 16'h2100

// serial frame: command byte then data byte, msb first
`define TFR_CMD_BIT_WRITE 7
`define TFR_CNT_W 4
`define TFR_CNT_CMD_LAST 4'h7
`define TFR_CNT_DATA_FIRST 4'h8
`define TFR_CNT_DATA_LAST 4'hf

`endif

/* rtl/tfr_spi_engine.sv */
// spi slave, mode 0, two-byte frames: command byte then data byte
// assumes sck, cs_n and mosi are already synchronised to clk
`timescale 1ns/100ps

module tfr_spi_engine
   import tfr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sck_s,
   input wire logic cs_n_s,
   input wire logic mosi_s,
   tfr_reg_if.eng bus,
   output logic miso
);
   logic sck_prev_reg;
   logic sck_rise;
   logic sck_fall;
   logic [`TFR_CNT_W-1:0] bit_cnt_reg;
   tfr_byte_t rx_shift_reg;
   tfr_byte_t cmd_reg;
   tfr_byte_t tx_shift_reg;
   tfr_byte_t wdata_reg;
   logic rd_pulse_reg;
   logic wr_pulse_reg;

   assign sck_rise = sck_s & ~sck_prev_reg & ~cs_n_s;
   assign sck_fall = ~sck_s & sck_prev_reg & ~cs_n_s;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_reg <= 1'b0;
         bit_cnt_reg <= '0;
         rx_shift_reg <= `TFR_BYTE_ZERO;
      end else begin
         sck_prev_reg <= sck_s;
         // counter wraps after the data byte so frames may follow in one select
         if (cs_n_s)
            bit_cnt_reg <= '0;
         else if (sck_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
         if (sck_rise)
            rx_shift_reg <= {rx_shift_reg[6:0], mosi_s};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_reg <= `TFR_BYTE_ZERO;
         rd_pulse_reg <= 1'b0;
         wr_pulse_reg <= 1'b0;
         wdata_reg <= `TFR_BYTE_ZERO;
      end else begin
         rd_pulse_reg <= 1'b0;
         wr_pulse_reg <= 1'b0;
         if (sck_rise && bit_cnt_reg == `TFR_CNT_CMD_LAST) begin
            cmd_reg <= {rx_shift_reg[6:0], mosi_s};
            rd_pulse_reg <= ~rx_shift_reg[`TFR_CMD_BIT_WRITE-1];
         end
         if (sck_rise && bit_cnt_reg == `TFR_CNT_DATA_LAST) begin
            wdata_reg <= {rx_shift_reg[6:0], mosi_s};
            wr_pulse_reg <= cmd_reg[`TFR_CMD_BIT_WRITE];
         end
      end
   end

   // the falling edge right after the command byte must not shift, or bit 7 is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         tx_shift_reg <= `TFR_BYTE_ZERO;
      else if (cs_n_s)
         tx_shift_reg <= `TFR_BYTE_ZERO;
      else if (rd_pulse_reg)
         tx_shift_reg <= bus.rdata;
      else if (sck_fall && bit_cnt_reg != `TFR_CNT_DATA_FIRST)
         tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
   end

   assign miso = tx_shift_reg[7];
   assign bus.addr = cmd_reg[`TFR_ADDR_W-1:0];
   assign bus.rd_pulse = rd_pulse_reg;
   assign bus.wr_pulse = wr_pulse_reg;
   assign bus.wdata = wdata_reg;
endmodule

/* sim/tfr_bank_bench.sv */
// self-checking bench of the fault register bank
// assumes the host model drives the serial pins
`timescale 1ns/100ps

module tfr_bank_bench
   import tfr_pkg::*;
;
   localparam logic [7:0] FLG [6] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
   logic clk;
   logic rst_n = 1'b0;
   logic sel = 1'b0;
   logic spi_pin = 1'b1;
   logic uart = 1'b0;
   logic tx_bit = 1'b0;
   logic transmit_enable_pin_bit = 1'b0;
   logic utx = 1'b0;
   logic utxen = 1'b0;
   logic rx = 1'b1;
   logic [5:0] cnd = 6'h00;
   logic [31:0] seed = 32'd61002;
   wire cs_n, sin, sclk, irq_n, sout, sout_oe, urx, ltx, ltxen;
   // a released data line shows the inverse, so a sample taken too early is caught
   wire miso_seen = sout_oe ? sout : ~sout;
   tfr_byte_t mode_o;
   int bad_count = 0;
   int tests_run = 0;

   tfr_bank u_dut (.clk(clk), .rst_n(rst_n), .spi_mode_pin(spi_pin),
      .serial_route_select(sel), .chip_sel_pin(cs_n), .shared_in_pin(sin),
      .shared_clock_pin(sclk), .uart_tx_pin(utx), .transmit_enable_pin(utxen),
      .line_rx_in(rx), .overheat_shutdown_in(cnd[5]), .driver_fault_in(cnd[3]),
      .supply_low_warn_in(cnd[2]), .supply_lockout_in(cnd[1]), .temp_warn_in(cnd[0]),
      .wakeup_detect_in(cnd[4]), .aux_input_low_in(1'b0), .line_level_low_in(1'b0),
      .fault_irq_out_n(irq_n), .shared_out_pin(sout), .shared_out_oe(sout_oe),
      .uart_rx_pin(urx),
      .line_tx_out(ltx), .line_transmit_enable_pin_out(ltxen), .mode_control_out(mode_o),
      .driver_current_limit_out(), .line_driver_config_out(), .aux_input_config_out(),
      .line_polarity_invert_out());
   tfr_host u_host (.cs_n(cs_n), .sin(sin), .sclk(sclk), .miso(miso_seen), .uart(uart),
      .tx_bit(tx_bit), .transmit_enable_pin_bit(transmit_enable_pin_bit));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [7:0] rmask(input logic [2:0] a);
      case (a)
         3'h2, 3'h3: return 8'hff;
         3'h4: return 8'hef;
         3'h5, 3'h6: return 8'h80;
         default: return 8'h00;
      endcase
   endfunction

   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic wcyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      logic [7:0] r;
      u_host.xfer({5'h10, a}, d, r);
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      u_host.xfer({5'h00, a}, 8'h00, d);
   endtask

   task automatic give_verdict();
      $display("counts: %0d checks, %0d mismatches", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #150us;
      bad_count++;
      give_verdict();
   end

   initial begin
      logic [7:0] r;
      logic [7:0] d;
      logic [31:0] v;
      wcyc(16);
      rst_n <= 1'b1;
      wcyc(8);
      for (int a = 0; a < 8; a++) begin
         rd(a[2:0], r);
         check(r, 8'h00);
      end
      $display("test reset values done");
      wr(3'h2, 8'h18);
      wcyc(4);
      check(mode_o, 8'h18);
      for (int a = 0; a < 8; a++) begin
         if (a == 2) continue;
         v = xs();
         d = v[7:0];
         wr(a[2:0], d);
         rd(a[2:0], r);
         check(r, d & rmask(a[2:0]));
      end
      $display("test register access done");
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         cnd[i] <= 1'b1;
         wcyc(20);
         cnd[i] <= 1'b0;
         wcyc(20);
         check(irq_n, 1'b0);
         rd(3'h0, r);
         check(r, FLG[i]);
         wcyc(20);
         check(irq_n, 1'b1);
      end
      $display("test single flags done");
      for (int j = 0; j < 2; j++) begin
         wr(3'h2, j ? 8'h58 : 8'h18);
         @(posedge clk);
         cnd <= 6'h3f;
         wcyc(20);
         // conditions stay high through the clearing read: no new edge, no new interrupt
         rd(3'h0, r);
         check(r, j ? 8'h9d : 8'hdd);
         wcyc(20);
         check(irq_n, 1'b1);
         cnd <= 6'h00;
         wcyc(20);
      end
      @(posedge clk);
      cnd <= 6'h21;
      wcyc(20);
      cnd <= 6'h00;
      wr(3'h2, 8'h80);
      wcyc(8);
      check(irq_n, 1'b1);
      wr(3'h2, 8'h18);
      rd(3'h0, r);
      check(r, 8'h00);
      $display("test grouped flags done");
      wcyc(1);
      // every fourth step drops the mode pin, where the dedicated transmit pins must pass
      for (int k = 0; k < 40; k++) begin
         v = xs();
         sel <= k[0];
         uart <= k[0];
         spi_pin <= (k[1:0] != 2'h3);
         tx_bit <= v[0];
         transmit_enable_pin_bit <= v[1];
         utx <= v[2];
         utxen <= v[3];
         rx <= v[4];
         wcyc(8);
         check(ltx, spi_pin ? k[0] & tx_bit : utx);
         check(ltxen, spi_pin ? k[0] & transmit_enable_pin_bit : utxen);
         check(urx, rx);
         if (k[1:0] == 2'h1) begin
            check(sout, rx);
            check(sout_oe, 1'b1);
         end
      end
      $display("test pin routing done");
      give_verdict();
   end
endmodule

/* sim/tfr_bank_props.sv */
// pin-level assertions on the fault register bank
// assumes it is bound into tfr_bank and sees only its ports
`timescale 1ns/100ps

module tfr_bank_props
   import tfr_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic spi_mode_pin,
   input wire logic serial_route_select,
   input wire logic chip_sel_pin,
   input wire logic shared_in_pin,
   input wire logic shared_clock_pin,
   input wire logic line_rx_in,
   input wire logic overheat_shutdown_in,
   input wire logic driver_fault_in,
   input wire logic supply_low_warn_in,
   input wire logic supply_lockout_in,
   input wire logic temp_warn_in,
   input wire logic wakeup_detect_in,
   input wire logic fault_irq_out_n,
   input wire logic shared_out_pin,
   input wire logic shared_out_oe,
   input wire logic uart_rx_pin,
   input wire logic line_tx_out,
   input wire logic line_transmit_enable_pin_out,
   input tfr_byte_t mode_control_out,
   input tfr_byte_t line_driver_config_out
);
   logic [5:0] cnd;
   logic [5:0] cnd_reg;
   logic [3:0] age_reg;
   wire spi_rt = spi_mode_pin && !serial_route_select && mode_control_out[4];
   wire uart_rt = spi_mode_pin && serial_route_select && mode_control_out[4];
   assign cnd = {overheat_shutdown_in, driver_fault_in, supply_low_warn_in,
      supply_lockout_in, temp_warn_in, wakeup_detect_in};

   // cycles since any condition rose, saturating so old events never count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnd_reg <= 6'h00;
         age_reg <= 4'hf;
      end else begin
         cnd_reg <= cnd;
         if ((cnd & ~cnd_reg) != 6'h00) begin
            age_reg <= 4'h0;
         end else if (age_reg != 4'hf) begin
            age_reg <= age_reg + 4'h1;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_spi;
      spi_rt [*4];
   endsequence
   sequence s_uart;
      (uart_rt && $stable(shared_in_pin) && $stable(shared_clock_pin)
         && $stable(line_rx_in)) [*6];
   endsequence

   property p_irq_clear;
      $rose(fault_irq_out_n) |-> !chip_sel_pin;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq released outside a frame");
   property p_irq_cause;
      $fell(fault_irq_out_n) |-> age_reg < 4'ha;
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("irq asserted with no event");
   property p_spi_quiet;
      s_spi |-> !line_tx_out && !line_transmit_enable_pin_out;
   endproperty
   a_spi_quiet: assert property (p_spi_quiet) else $error("dedicated tx leaks in spi route");
   property p_uart_pass;
      s_uart |-> line_tx_out == shared_in_pin && line_transmit_enable_pin_out == shared_clock_pin
         && shared_out_pin == line_rx_in;
   endproperty
   a_uart_pass: assert property (p_uart_pass) else $error("uart route mismatch");
   property p_oe_on;
      (spi_rt && !chip_sel_pin) [*5] |-> shared_out_oe;
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
   property p_oe_off;
      (spi_rt && chip_sel_pin) [*5] |-> !shared_out_oe;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("miso driven while deselected");
   property p_rx_live;
      $stable(line_rx_in) [*5] |-> uart_rx_pin == line_rx_in;
   endproperty
   a_rx_live: assert property (p_rx_live) else $error("receive pin not following line");
   property p_cfg_write;
      !$stable(line_driver_config_out) |-> !chip_sel_pin;
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("register changed outside a frame");
   cover property (s_uart);
endmodule

bind tfr_bank tfr_bank_props u_props (.*);

/* sim/tfr_host.sv */
// host microcontroller model: spi master, mode 0, on the shared pins
// assumes sck of 80 ns period, clock idles low between frames
`timescale 1ns/100ps

module tfr_host (
   output logic cs_n,
   output logic sin,
   output logic sclk,
   input wire logic miso,
   input wire logic uart,
   input wire logic tx_bit,
   input wire logic transmit_enable_pin_bit
);
   logic sck_r = 1'b0;
   logic mosi_r = 1'b0;
   assign sin = uart ? tx_bit : mosi_r;
   assign sclk = uart ? transmit_enable_pin_bit : sck_r;
   initial cs_n = 1'b1;

   // odd offset keeps the link clock out of phase with the bank clock
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      #1.3 cs_n = 1'b0;
      for (int i = 0; i < 16; i++) begin
         mosi_r = sh[15];
         #40 sck_r = 1'b1;
         if (i > 7) rd = {rd[6:0], miso};
         sh = {sh[14:0], 1'b0};
         #40 sck_r = 1'b0;
      end
      #40 cs_n = 1'b1;
      #80;
   endtask
endmodule
